// [src/eel_defines.svh]
`ifndef EEL_DEFINES_SVH
`define EEL_DEFINES_SVH

// ==========================================================
// register byte offsets
`define EEL_OFS_CTRL    8'h00
`define EEL_OFS_STATUS  8'h04
`define EEL_OFS_MASK    8'h08
`define EEL_OFS_COUNT   8'h0C
`define EEL_OFS_PINS    8'h10
`define EEL_OFS_RESUME  8'h14

// ==========================================================
// control field positions
`define EEL_CTRL_MODE_LO  0
`define EEL_CTRL_MODE_HI  1
`define EEL_CTRL_HALT_EN  2
`define EEL_CTRL_RUN      3
`define EEL_CTRL_EVT0     4
`define EEL_CTRL_EVT1     5

// status / mask field positions
`define EEL_ST_HALT   0
`define EEL_ST_LOW0   1
`define EEL_ST_LOW1   2
`define EEL_ST_CARRY  3

// ==========================================================
// reset values and widths
`define EEL_CTRL_RST   6'h00
`define EEL_MASK_RST   4'h0
`define EEL_CNT_RST    16'h0000
`define EEL_CNT_MAX    16'hFFFF
`define EEL_RESP_OKAY  2'h0
`define EEL_RESP_SLV   2'h2

`endif

// [src/eel_pkg.sv]
`default_nettype none
package eel_pkg;
  // pin operating mode of both event lines
  typedef enum logic [1:0] {
    EEL_MODE_HIZ   = 2'b00,
    EEL_MODE_EVENT = 2'b01,
    EEL_MODE_COUNT = 2'b10
  } eel_mode_t;
endpackage
`default_nettype wire

// [src/eel_pin_drv.sv]
`default_nettype none
// ==========================================================
// one event line output stage
module eel_pin_drv (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire eel_pkg::eel_mode_t mode,
  input  wire logic              evt_req,
  input  wire logic              cnt_val,
  output logic                   pin_out,
  output logic                   pin_oe_n
);
  // registered so the pad sees no decode glitches
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      case (mode)
        // R02: low only
        eel_pkg::EEL_MODE_EVENT: begin
          pin_out  <= 1'b0;
          pin_oe_n <= ~evt_req; // released line floats high on pull-up
        end
        // R03: totem pole
        eel_pkg::EEL_MODE_COUNT: begin
          pin_out  <= cnt_val;
          pin_oe_n <= 1'b0;
        end
        // R01: inactive is hiz
        default: begin
          pin_out  <= 1'b0;
          pin_oe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [src/eel_top.sv]
`include "eel_defines.svh"
`default_nettype none
// How it works
// R01: each event line is tri-state and floats whenever not in an active mode.
// R02: event mode drives a line only low, like an open collector.
// R03: counting mode drives both lines as push-pull outputs for a counter.
// R04: outside sources stay quiet while any device is in counting mode.
// R05: with halt enabled, a low event line halts the processor; the code never halts while in counting mode.
// R06: board pulse generator pulses input bus low on each output bus low.
// R07: that pulse lasts over one test clock period and under 10 us.
// R08: counting mode puts counter carry on line one, halted flag on zero.
// R09: board input bus stays high during any benchmark or analysis count.
// R10: a counting-enable input stops the pulse generator driving low.
// R11: board edge splits the shared event signal into input and output.
// R12: software returns the board output line high after an event.
// R13: controller mode select feeds all TMS; scan chain loops to controller.
// R14: chain reset is inverted controller event three, or board logic.
// R15: pulse generator counts test clocks and re-arms after bus returns high.
module eel_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        test_clk,
  input  wire logic        core_event_0,
  input  wire logic        core_event_1,
  input  wire logic        emulation_event_line_0_in,
  output logic             emulation_event_line_0_out,
  output logic             emulation_event_line_0_oe_n,
  input  wire logic        emulation_event_line_1_in,
  output logic             emulation_event_line_1_out,
  output logic             emulation_event_line_1_oe_n,
  output logic             cpu_halt,
  output logic             irq
);
  // ========================================================
  // state
  logic [5:0]        ctrl_r;
  logic [3:0]        status_r, mask_r, status_nxt;
  logic [15:0]       cnt_r;
  logic              carry_r, halt_r;
  logic [2:0]        tck_sync_r;
  logic [1:0]        l0_sync_r, l1_sync_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              aw_got_r, w_got_r;
  eel_pkg::eel_mode_t mode;
  logic              do_wr, tck_rise, line_low, halt_trig, cnt_step;

  // unknown mode codes fall back to floating pins
  always_comb begin
    case (ctrl_r[`EEL_CTRL_MODE_HI:`EEL_CTRL_MODE_LO])
      2'h1:    mode = eel_pkg::EEL_MODE_EVENT;
      2'h2:    mode = eel_pkg::EEL_MODE_COUNT;
      default: mode = eel_pkg::EEL_MODE_HIZ;
    endcase
  end

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `EEL_OFS_CTRL) || (a == `EEL_OFS_STATUS) ||
                (a == `EEL_OFS_MASK) || (a == `EEL_OFS_COUNT) ||
                (a == `EEL_OFS_PINS) || (a == `EEL_OFS_RESUME);
  endfunction

  // ========================================================
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tck_sync_r <= 3'h0;
      l0_sync_r  <= 2'h3;
      l1_sync_r  <= 2'h3;
    end else begin
      tck_sync_r <= {tck_sync_r[1:0], test_clk};
      l0_sync_r  <= {l0_sync_r[0], emulation_event_line_0_in};
      l1_sync_r  <= {l1_sync_r[0], emulation_event_line_1_in};
    end
  end
  assign tck_rise = tck_sync_r[1] & ~tck_sync_r[2];
  assign line_low = ~l0_sync_r[1] | ~l1_sync_r[1];
  // halting is judged on test clock edges, since a valid event low
  // lasts at least one test clock period; own count drive never halts
  assign halt_trig = ctrl_r[`EEL_CTRL_HALT_EN] & tck_rise & line_low &
                     (mode != eel_pkg::EEL_MODE_COUNT);

  // ========================================================
  // axi4-lite write channel: address and data in either order
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
  assign do_wr         = aw_got_r & w_got_r & ~s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EEL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(awaddr_r) ? `EEL_RESP_OKAY
                                            : `EEL_RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and mask registers; all fields sit in byte lane 0
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r <= `EEL_CTRL_RST;
      mask_r <= `EEL_MASK_RST;
    end else if (do_wr && wstrb_r[0]) begin
      if (awaddr_r == `EEL_OFS_CTRL) ctrl_r <= wdata_r[5:0];
      if (awaddr_r == `EEL_OFS_MASK) mask_r <= wdata_r[3:0];
    end
  end

  // ========================================================
  // R05: halt on low line
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      halt_r <= 1'b0;
    end else if (halt_trig) begin
      halt_r <= 1'b1; // a new event beats a resume in the same cycle
    end else if (do_wr && awaddr_r == `EEL_OFS_RESUME) begin
      halt_r <= 1'b0;
    end
  end
  assign cpu_halt = halt_r;

  // analysis counter runs only while counting and not halted
  assign cnt_step = (mode == eel_pkg::EEL_MODE_COUNT) &
                    ctrl_r[`EEL_CTRL_RUN] & ~halt_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r   <= `EEL_CNT_RST;
      carry_r <= 1'b0;
    end else begin
      carry_r <= cnt_step && (cnt_r == `EEL_CNT_MAX);
      if (cnt_step) cnt_r <= cnt_r + 16'h0001;
    end
  end

  // ========================================================
  // sticky status, write one to clear, set wins over clear
  always_comb begin
    status_nxt = status_r;
    if (do_wr && wstrb_r[0] && awaddr_r == `EEL_OFS_STATUS)
      status_nxt = status_r & ~wdata_r[3:0];
    if (halt_trig)       status_nxt[`EEL_ST_HALT]  = 1'b1;
    if (~l0_sync_r[1])   status_nxt[`EEL_ST_LOW0]  = 1'b1;
    if (~l1_sync_r[1])   status_nxt[`EEL_ST_LOW1]  = 1'b1;
    if (carry_r)         status_nxt[`EEL_ST_CARRY] = 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) status_r <= 4'h0;
    else        status_r <= status_nxt;
  end
  assign irq = |(status_r & mask_r);

  // ========================================================
  // axi4-lite read channel, one cycle to rvalid
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `EEL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? `EEL_RESP_OKAY
                                              : `EEL_RESP_SLV;
      case (s_axi_araddr)
        `EEL_OFS_CTRL:   s_axi_rdata <= {26'h0, ctrl_r};
        `EEL_OFS_STATUS: s_axi_rdata <= {28'h0, status_r};
        `EEL_OFS_MASK:   s_axi_rdata <= {28'h0, mask_r};
        `EEL_OFS_COUNT:  s_axi_rdata <= {16'h0, cnt_r};
        `EEL_OFS_PINS:   s_axi_rdata <= {29'h0, halt_r,
                                          l1_sync_r[1], l0_sync_r[1]};
        default:         s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ========================================================
  // pin stages
  // R08: line 0 halted, line 1 carry
  eel_pin_drv u_line0 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .mode     (mode),
    .evt_req  (ctrl_r[`EEL_CTRL_EVT0] | core_event_0),
    .cnt_val  (halt_r),
    .pin_out  (emulation_event_line_0_out),
    .pin_oe_n (emulation_event_line_0_oe_n)
  );
  eel_pin_drv u_line1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .mode     (mode),
    .evt_req  (ctrl_r[`EEL_CTRL_EVT1] | core_event_1),
    .cnt_val  (carry_r),
    .pin_out  (emulation_event_line_1_out),
    .pin_oe_n (emulation_event_line_1_oe_n)
  );

  // ========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_hiz_when_idle: assert property ( // R01
    mode == eel_pkg::EEL_MODE_HIZ |=>
      emulation_event_line_0_oe_n && emulation_event_line_1_oe_n)
    else $error("event line driven while idle");

  a_event_low_only: assert property ( // R02
    mode == eel_pkg::EEL_MODE_EVENT && ctrl_r[`EEL_CTRL_EVT0] |=>
      !emulation_event_line_0_oe_n && !emulation_event_line_0_out)
    else $error("event request not pulling line low");

  a_event_no_high: assert property ( // R02
    mode == eel_pkg::EEL_MODE_EVENT |=>
      !emulation_event_line_1_out)
    else $error("event mode drove line high");

  a_count_totem: assert property ( // R03
    mode == eel_pkg::EEL_MODE_COUNT |=>
      !emulation_event_line_0_oe_n && !emulation_event_line_1_oe_n)
    else $error("count mode not driving both lines");

  a_halt_on_low: assert property ( // R05
    halt_trig |=> cpu_halt ##0 status_r[`EEL_ST_HALT])
    else $error("low line did not halt");

  a_count_outputs: assert property ( // R08
    mode == eel_pkg::EEL_MODE_COUNT |=>
      emulation_event_line_0_out == $past(halt_r) &&
      emulation_event_line_1_out == $past(carry_r))
    else $error("count mode outputs wrong");

  c_halt_seen:  cover property (halt_trig ##1 cpu_halt);
  c_carry_out:  cover property (carry_r ##1 emulation_event_line_1_out);
  c_event_pull: cover property (!emulation_event_line_0_oe_n &&
                                mode == eel_pkg::EEL_MODE_EVENT);
endmodule
`default_nettype wire

// [sim/eel_board.sv]
`default_nettype none
// ==========================================================
// board side of both event lines: pull-ups, pulse generator,
// other boards and the scan chain back to the bus controller
module eel_board (
  input  wire logic       test_clk,
  input  wire logic [1:0] dev_out,
  input  wire logic [1:0] dev_oe_n,
  input  wire logic [1:0] ext_low,
  input  wire logic       count_mode,
  input  wire logic       scan_out,
  input  wire logic       controller_event_three,
  output logic      [1:0] line,
  output logic            controller_scan_return
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE_TCK = 2;
  int         width_r [2] = '{0, 0};
  logic [1:0] armed_r = 2'b11;
  logic [1:0] board_event_in;
  logic [1:0] chain_r = 2'b00;
  logic       chain_trst_n;

  // ==========================================================
  // pulse generator, timed by the test clock
  // a low on another board's output bus starts one pulse
  // two test clocks: over one period, far under 10 us
  // the counting enable keeps the input bus high throughout
  // re-arm waits until software returns the output bus high
  always @(posedge test_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (width_r[i] > 0) begin
        width_r[i] <= width_r[i] - 1;
      end else if (ext_low[i] && armed_r[i] && !count_mode) begin
        width_r[i] <= PULSE_TCK;
        armed_r[i] <= 1'b0;
      end else if (!ext_low[i]) begin
        armed_r[i] <= 1'b1;
      end
    end
  end

  // pull-up wire, the pulse comes in on its own input path
  // the pulse never drives while counting, so no totem clash
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      board_event_in[i] = (width_r[i] == 0) || count_mode;
      line[i] = dev_oe_n[i] ? 1'b1 : dev_out[i];
      if (!board_event_in[i])
        line[i] = 1'b0;
    end
  end

  // ==========================================================
  // scan chain: one bypass bit in each of two devices
  // chain reset is the inverse of controller event three
  assign chain_trst_n = ~controller_event_three;
  // controller output feeds the first device, the last returns
  always @(posedge test_clk) begin
    if (!chain_trst_n)
      chain_r <= 2'b00;
    else
      chain_r <= {chain_r[0], scan_out};
  end
  assign controller_scan_return = chain_r[1];
endmodule
`default_nettype wire

// [sim/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, test_clk, cnt_mode, cpu_halt, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rd2;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, core_event_0, core_event_1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ext_low, oe_n, pin_out, line;
  logic [1:0]  rsp, e, c;
  int          n_errors, n_checks, m;
  logic        scan_bit, evt_three, scan_ret;
  int unsigned exp_q[$];

  eel_top u_eel_top (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .test_clk,
    .core_event_0, .core_event_1,
    .emulation_event_line_0_in(line[0]),
    .emulation_event_line_0_out(pin_out[0]),
    .emulation_event_line_0_oe_n(oe_n[0]),
    .emulation_event_line_1_in(line[1]),
    .emulation_event_line_1_out(pin_out[1]),
    .emulation_event_line_1_oe_n(oe_n[1]), .cpu_halt, .irq);
  eel_board u_eel_board (.test_clk, .dev_out(pin_out), .dev_oe_n(oe_n),
    .ext_low, .count_mode(cnt_mode), .scan_out(scan_bit),
    .controller_event_three(evt_three), .line,
    .controller_scan_return(scan_ret));

  // ==========================================================
  // clocks: test clock free running, unrelated in phase
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    test_clk = 1'b0;
    #7;
    forever #100 test_clk = ~test_clk;
  end

  // ==========================================================
  // bus tasks: driven just after a rising edge; handshakes and
  // answers are taken at the rising edge where they complete
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw, w, b;
    aw = 1'b1; w = 1'b1; b = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      if (s_axi_bvalid) begin b = 1'b1; r = s_axi_bresp; end
      s_axi_awvalid <= aw; s_axi_wvalid <= w; s_axi_bready <= !b;
    end while (!b);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar, v;
    ar = 1'b1; v = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) ar = 1'b0;
      if (s_axi_rvalid) begin v = 1'b1; d = s_axi_rdata; r = s_axi_rresp; end
      s_axi_arvalid <= ar; s_axi_rready <= !v;
    end while (!v);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // halt level is awaited under a bound, then compared
  task automatic wait_halt(input logic v);
    int t;
    t = 0;
    while (cpu_halt !== v && t < 200) begin @(negedge core_clk); t++; end
    chk(cpu_halt, v);
  endtask
  // expected enables: low only where the pad is driven
  function automatic logic [1:0] exp_oe(int md, logic [1:0] ev);
    if (md == 1) return ~ev;
    if (md == 2) return 2'b00;
    return 2'b11;
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog: the counter wrap makes the tests about 66k cycles long
  initial begin
    #2_400_000;
    n_errors++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF; s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; core_event_0 = 1'b0; core_event_1 = 1'b0;
    ext_low = 2'b00; cnt_mode = 1'b0; n_errors = 0; n_checks = 0;
    scan_bit = 1'b0; evt_three = 1'b1;
    void'($urandom(32'h5F96AE30));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    axr(8'h00, rd, rsp); chk(rd, 32'h0);
    axr(8'h08, rd, rsp); chk(rd, 32'h0);
    @(negedge core_clk); chk(oe_n, 2'b11);
    axr(8'h18, rd, rsp); chk(rsp, 2'h2); chk(rd, 32'h0);
    axw(8'h18, 32'hFF, rsp); chk(rsp, 2'h2);
    // chain held in reset, then a one walks through both devices
    @(negedge core_clk); chk(scan_ret, 1'b0);
    @(posedge core_clk);
    evt_three <= 1'b0; scan_bit <= 1'b1;
    repeat (3) @(posedge test_clk);
    @(negedge core_clk); chk(scan_ret, 1'b1);
    $display("test reset_map done");
    // every mode with random software and core events
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      m = i % 4; e = 2'($urandom); c = 2'($urandom);
      core_event_0 <= c[0]; core_event_1 <= c[1];
      exp_q.push_back(32'(e * 16 + m));
      axw(8'h00, 32'(e * 16 + m), rsp);
      axr(8'h00, rd, rsp); chk(rd, exp_q.pop_front());
      repeat (3) @(negedge core_clk);
      chk(oe_n, exp_oe(m, e | c));
      if (m == 1) chk(pin_out & ~oe_n, 2'b00);
    end
    $display("test modes done");
    @(posedge core_clk);
    core_event_0 <= 1'b0; core_event_1 <= 1'b0;
    axw(8'h04, 32'hF, rsp);
    axw(8'h08, 32'h2, rsp);
    @(negedge core_clk); chk(irq, 1'b0);
    axw(8'h00, 32'h11, rsp);
    repeat (8) @(negedge core_clk);
    chk({line, irq}, 3'b101);
    axw(8'h00, 32'h01, rsp);
    axw(8'h04, 32'hF, rsp);
    @(negedge core_clk); chk(irq, 1'b0);
    $display("test event_irq done");
    // another board pulls line one low while halting is enabled
    axw(8'h00, 32'h05, rsp);
    ext_low <= 2'b10;
    wait_halt(1'b1);
    @(posedge core_clk);
    // software returns the other board's output bus high
    ext_low <= 2'b00;
    axr(8'h04, rd, rsp); chk(rd, 32'h5);
    // counting mode while halted: line zero shows the halt
    axw(8'h00, 32'h0A, rsp);
    cnt_mode <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk({oe_n, pin_out[0]}, 3'b001);
    axw(8'h14, 32'h0, rsp);
    wait_halt(1'b0);
    repeat (3) @(negedge core_clk); chk(pin_out[0], 1'b0);
    axr(8'h0C, rd, rsp);
    axr(8'h0C, rd2, rsp); chk(rd2 - rd, 32'h3);
    // run on until the counter wraps and its carry shows on line one
    m = 0;
    while (pin_out[1] !== 1'b1 && m < 70000) begin
      @(negedge core_clk); m++;
    end
    chk(pin_out[1], 1'b1);
    axr(8'h04, rd, rsp); chk(rd, 32'hF);
    axw(8'h00, 32'h00, rsp);
    cnt_mode <= 1'b0;
    repeat (3) @(negedge core_clk); chk(oe_n, 2'b11);
    $display("test halt_count done");
    report_and_stop();
  end
endmodule
`default_nettype wire
